// ==== hw/boron_dilution_block.sv ====
// Top level of the boron dilution block demand logic.

// Function
// RQ1: Any of three conditions raises block demand.
// RQ2: Average count rate, compare with lagged average.
// RQ3: Ratio above threshold gives division partial trip.
// RQ4: Flux demand needs two of four trips.
// RQ5: Manual block, reinstated below permissive.
// RQ6: Reinstatement passes a one-shot into latch.
// RQ7: Manual reset accepted at any time.
// RQ8: Ratio threshold is nominally 2.2.
// RQ9: Flux demand closes makeup and water valves.
// RQ10: Flux demand also trips makeup pumps.
// RQ11: Power loss or trip: close, align acid; here only the water valves close, makeup stays open.
// RQ12: Loss of ac qualified by short delay.
// RQ13: Charger undervoltage needs both sensors.
// RQ14: Loss when A/C coincides with B/D.
// RQ15: Trip interlock acts like loss of ac.
// RQ16: All logic runs on one periodic tick; here only sampling, the ac loss timer and demand setting wait for it.
// RQ17: Reset clears state, outputs held off.
// RQ18: Demands stay latched until manual reset.
module boron_dilution_block (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Count rates, one per division
  input wire logic [bdb_pkg::RATE_W-1:0] RATE_A_IN,
  input wire logic [bdb_pkg::RATE_W-1:0] RATE_B_IN,
  input wire logic [bdb_pkg::RATE_W-1:0] RATE_C_IN,
  input wire logic [bdb_pkg::RATE_W-1:0] RATE_D_IN,
  // Charger undervoltage sensors, two per division, bit 2k and 2k+1
  input wire logic [7:0] UV_SENSE_IN,
  // Reactor trip interlock, one per division
  input wire logic [3:0] TRIP_ILK_IN,
  // Operator and permissive inputs
  input wire logic MAN_BLOCK_IN,
  input wire logic MAN_RESET_IN,
  input wire logic BELOW_PERM_IN,
  // Software register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // Actuation demands
  output logic MAKEUP_ISO_CLOSE_OUT,
  output logic DEMIN_CLOSE_OUT,
  output logic ACID_ALIGN_OUT,
  output logic PUMP_TRIP_OUT,
  output logic FLUX_BLOCKED_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [14:0] sync1_r;
  logic [14:0] sync2_r;
  logic [14:0] raw_pins;
  logic [7:0] uv_s;
  logic [3:0] ilk_s;
  logic man_block_s;
  logic man_reset_s;
  logic below_perm_s;

  assign raw_pins = {BELOW_PERM_IN, MAN_RESET_IN, MAN_BLOCK_IN, TRIP_ILK_IN, UV_SENSE_IN};

  // The stages carry no reset: they keep following the pins through reset,
  // so a level held across reset gives no false edge to the one-shots.
  always_ff @(posedge CLK_IN) begin
    sync1_r <= raw_pins;
    sync2_r <= sync1_r;
  end

  assign uv_s = sync2_r[7:0];
  assign ilk_s = sync2_r[11:8];
  assign man_block_s = sync2_r[12];
  assign man_reset_s = sync2_r[13];
  assign below_perm_s = sync2_r[14];

  // Count rates are multi-bit and arrive from outside; they are staged twice.
  logic [bdb_pkg::RATE_W-1:0] rate_s1_r [4];
  logic [bdb_pkg::RATE_W-1:0] rate_s2_r [4];
  logic [bdb_pkg::RATE_W-1:0] rate_pin [4];
  assign rate_pin[0] = RATE_A_IN;
  assign rate_pin[1] = RATE_B_IN;
  assign rate_pin[2] = RATE_C_IN;
  assign rate_pin[3] = RATE_D_IN;

  // ---------------------------------------------------------------
  // Sample tick
  // ---------------------------------------------------------------
  // Every timer below counts these ticks, not clocks, so the sample period
  // can change without touching the delays that are counted in samples.
  logic [15:0] tick_cnt_r;
  logic tick;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == 16'(bdb_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = (tick_cnt_r == 16'(bdb_pkg::TICK_CYCLES - 1)); // see RQ16

  // ---------------------------------------------------------------
  // Per-division trend calculation
  // ---------------------------------------------------------------
  logic [3:0] part_trip;
  logic [3:0] div_valid;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_div
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          rate_s1_r[g] <= '0;
          rate_s2_r[g] <= '0;
        end else begin
          rate_s1_r[g] <= rate_pin[g];
          rate_s2_r[g] <= rate_s1_r[g];
        end
      end
      rate_trend u_trend (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .tick_in(tick),
        .rate_in(rate_s2_r[g]),
        .trip_out(part_trip[g]),
        .valid_out(div_valid[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Two of four voting
  // ---------------------------------------------------------------
  // A division still filling its history cannot vote, so a fresh start never
  // trips on a half-empty window.
  logic [2:0] trip_count;
  logic flux_vote;
  always_comb begin
    trip_count = 3'h0;
    for (int i = 0; i < 4; i++) begin
      trip_count = trip_count + {2'h0, part_trip[i] & div_valid[i]};
    end
  end
  assign flux_vote = (trip_count >= 3'h2); // see RQ4

  // ---------------------------------------------------------------
  // Manual block with automatic reinstatement
  // ---------------------------------------------------------------
  logic reinstate_pulse;
  logic block_edge;
  logic flux_blocked_r;

  one_shot u_reinstate (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .lvl_in(below_perm_s),
    .pulse_out(reinstate_pulse) // see RQ6
  );
  one_shot u_block (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .lvl_in(man_block_s),
    .pulse_out(block_edge)
  );

  // Only the entry edge below permissive clears the block, so a later
  // manual block while still below permissive is honoured.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      flux_blocked_r <= 1'b0;
    end else if (reinstate_pulse) begin
      flux_blocked_r <= 1'b0; // see RQ5 see RQ6
    end else if (block_edge) begin
      flux_blocked_r <= 1'b1; // see RQ5
    end
  end

  // ---------------------------------------------------------------
  // Loss of ac power qualification
  // ---------------------------------------------------------------
  logic [3:0] chg_uv;
  logic uv_coinc;
  logic [7:0] uv_cnt_r;
  logic loss_ac;

  generate
    for (g = 0; g < 4; g++) begin : gen_chg
      assign chg_uv[g] = uv_s[2*g] & uv_s[2*g+1]; // see RQ13
    end
  endgenerate
  assign uv_coinc = (chg_uv[0] | chg_uv[2]) & (chg_uv[1] | chg_uv[3]); // see RQ14

  // Any dropout of the coincidence restarts the count, so a flickering supply
  // must stay low for the whole delay before it counts as lost.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      uv_cnt_r <= '0;
    end else if (!uv_coinc) begin
      uv_cnt_r <= '0; // see RQ12
    end else if (tick && uv_cnt_r != 8'(bdb_pkg::UV_DELAY_TICKS)) begin
      uv_cnt_r <= uv_cnt_r + 8'h01;
    end
  end
  assign loss_ac = (uv_cnt_r == 8'(bdb_pkg::UV_DELAY_TICKS)); // see RQ12

  // Reactor trip interlock voted two of four per divisions.
  logic [2:0] ilk_count;
  logic ilk_vote;
  always_comb begin
    ilk_count = 3'h0;
    for (int i = 0; i < 4; i++) begin
      ilk_count = ilk_count + {2'h0, ilk_s[i]};
    end
  end
  assign ilk_vote = (ilk_count >= 3'h2); // see RQ15

  // ---------------------------------------------------------------
  // Demand latches
  // ---------------------------------------------------------------
  logic reset_pulse;
  logic flux_dem_r;
  logic power_dem_r;

  one_shot u_reset (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .lvl_in(man_reset_s),
    .pulse_out(reset_pulse)
  );

  // A standing condition re-sets the latch after a reset, so a reset
  // only clears demands whose cause is gone.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      flux_dem_r <= 1'b0; // see RQ17
    end else if (flux_vote && !flux_blocked_r && tick) begin
      flux_dem_r <= 1'b1; // see RQ1 see RQ4
    end else if (reset_pulse) begin
      flux_dem_r <= 1'b0; // see RQ7 see RQ18
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      power_dem_r <= 1'b0; // see RQ17
    end else if ((loss_ac || ilk_vote) && tick) begin
      power_dem_r <= 1'b1; // see RQ1 see RQ15
    end else if (reset_pulse) begin
      power_dem_r <= 1'b0; // see RQ18
    end
  end

  // ---------------------------------------------------------------
  // Actuation outputs
  // ---------------------------------------------------------------
  // Makeup isolation closes on the flux demand only; a power loss keeps
  // makeup available, drawn from the acid tank.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      MAKEUP_ISO_CLOSE_OUT <= 1'b0;
      DEMIN_CLOSE_OUT <= 1'b0;
      ACID_ALIGN_OUT <= 1'b0;
      PUMP_TRIP_OUT <= 1'b0;
      FLUX_BLOCKED_OUT <= 1'b0;
    end else begin
      MAKEUP_ISO_CLOSE_OUT <= flux_dem_r; // see RQ9 see RQ11
      DEMIN_CLOSE_OUT <= flux_dem_r | power_dem_r; // see RQ9 see RQ11
      ACID_ALIGN_OUT <= power_dem_r; // see RQ11
      PUMP_TRIP_OUT <= flux_dem_r; // see RQ10
      FLUX_BLOCKED_OUT <= flux_blocked_r;
    end
  end

  // ---------------------------------------------------------------
  // Event status, mask and register port
  // ---------------------------------------------------------------
  // Status bits, low to high: flux demand rise, power demand rise, any
  // partial trip, reinstatement.
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [3:0] events;
  logic flux_dem_d_r;
  logic power_dem_d_r;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      flux_dem_d_r <= 1'b0;
      power_dem_d_r <= 1'b0;
    end else begin
      flux_dem_d_r <= flux_dem_r;
      power_dem_d_r <= power_dem_r;
    end
  end

  assign events = {reinstate_pulse, |part_trip, power_dem_r & ~power_dem_d_r, flux_dem_r & ~flux_dem_d_r};

  // A new event in the cycle of a clear write keeps its bit set.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      status_r <= '0;
    end else if (REG_WR_IN && REG_ADDR_IN == bdb_pkg::ADDR_STATUS) begin
      status_r <= (status_r & ~REG_WDATA_IN[3:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mask_r <= '0;
    end else if (REG_WR_IN && REG_ADDR_IN == bdb_pkg::ADDR_MASK) begin
      mask_r <= REG_WDATA_IN[3:0];
    end
  end

  assign IRQ_OUT = |(status_r & mask_r);

  // Read data stand for one cycle only and drop to zero otherwise, so a stale
  // value is never mistaken for a fresh read.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        bdb_pkg::ADDR_STATUS: REG_RDATA_OUT <= {28'h0, status_r};
        bdb_pkg::ADDR_MASK: REG_RDATA_OUT <= {28'h0, mask_r};
        bdb_pkg::ADDR_STATE: REG_RDATA_OUT <= {20'h0, div_valid, part_trip, flux_blocked_r,
                                      loss_ac, power_dem_r, flux_dem_r};
        default: REG_RDATA_OUT <= '0;
      endcase
    end else begin
      REG_RDATA_OUT <= '0;
    end
  end
endmodule

// ==== hw/bdb_pkg.sv ====
// Shared constants for the dilution block logic.
package bdb_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  // Sample tick period in microseconds and its cycle count.
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  // Number of samples per average.
  localparam int unsigned AVG_SAMPLES = 16;
  localparam int unsigned AVG_SHIFT = 4;
  // Lag between current and earlier average, in samples.
  localparam int unsigned LAG_SAMPLES = 32;
  // Loss of ac qualifying delay, in ticks.
  localparam int unsigned UV_DELAY_TICKS = 100;
  // ---------------------------------------------------------------
  // Data widths and threshold
  // ---------------------------------------------------------------
  localparam int unsigned RATE_W = 16;
  localparam int unsigned HIST_DEPTH = 64;
  localparam int unsigned HIST_AW = 6;
  // Ratio threshold 2.2 held as numerator over denominator.
  localparam logic [3:0] RATIO_NUM = 4'hB;
  localparam logic [3:0] RATIO_DEN = 4'h5;
  localparam logic [3:0] DIV_ALL_RST = 4'h0;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;
endpackage

// ==== hw/one_shot.sv ====
// Rising edge detector giving a single-cycle pulse.
module one_shot (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic lvl_in,
  output logic pulse_out
);
  logic prev_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= lvl_in;
    end
  end
  // Reset holds prev high so a level present at reset gives no pulse.
  assign pulse_out = lvl_in & ~prev_r;
endmodule

// ==== hw/rate_trend.sv ====
// Per-division count-rate averaging and trend comparison.
module rate_trend (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic [bdb_pkg::RATE_W-1:0] rate_in,
  output logic trip_out,
  output logic valid_out
);
  logic [bdb_pkg::RATE_W-1:0] hist_mem [bdb_pkg::HIST_DEPTH];
  logic [bdb_pkg::HIST_AW-1:0] wptr_r;
  logic [bdb_pkg::HIST_AW:0] fill_r;
  logic [bdb_pkg::RATE_W+bdb_pkg::AVG_SHIFT-1:0] sum_now_r;
  logic [bdb_pkg::RATE_W+bdb_pkg::AVG_SHIFT-1:0] sum_old_r;
  logic [bdb_pkg::RATE_W-1:0] leave_now;
  logic [bdb_pkg::RATE_W-1:0] enter_old;
  logic [bdb_pkg::RATE_W-1:0] leave_old;
  logic [bdb_pkg::RATE_W+bdb_pkg::AVG_SHIFT+3:0] lhs;
  logic [bdb_pkg::RATE_W+bdb_pkg::AVG_SHIFT+3:0] rhs;
  logic full;

  // ---------------------------------------------------------------
  // Sliding window sums over history
  // ---------------------------------------------------------------
  assign leave_now = hist_mem[wptr_r - 6'(bdb_pkg::AVG_SAMPLES)];
  assign enter_old = hist_mem[wptr_r - 6'(bdb_pkg::LAG_SAMPLES)];
  assign leave_old = hist_mem[wptr_r - 6'(bdb_pkg::LAG_SAMPLES + bdb_pkg::AVG_SAMPLES)];
  assign full = (fill_r >= 7'(bdb_pkg::LAG_SAMPLES + bdb_pkg::AVG_SAMPLES));

  always_ff @(posedge clk_in) begin
    if (tick_in) begin
      hist_mem[wptr_r] <= rate_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin // see RQ17
      wptr_r <= '0;
      fill_r <= '0;
      sum_now_r <= '0;
      sum_old_r <= '0;
    end else if (tick_in) begin // see RQ16
      wptr_r <= wptr_r + 6'h01;
      if (!full) begin
        fill_r <= fill_r + 7'h01;
      end
      // Entries not yet written are excluded until the window fills.
      sum_now_r <= sum_now_r + rate_in
        - ((fill_r >= 7'(bdb_pkg::AVG_SAMPLES)) ? leave_now : '0); // see RQ2
      sum_old_r <= sum_old_r
        + ((fill_r >= 7'(bdb_pkg::LAG_SAMPLES)) ? enter_old : '0)
        - (full ? leave_old : '0); // see RQ2
    end
  end

  // ---------------------------------------------------------------
  // Ratio test: now/old > NUM/DEN, done without a divider
  // ---------------------------------------------------------------
  assign lhs = {4'h0, sum_now_r} * bdb_pkg::RATIO_DEN;
  assign rhs = {4'h0, sum_old_r} * bdb_pkg::RATIO_NUM;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trip_out <= 1'b0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= full;
      trip_out <= full && (lhs > rhs); // see RQ3 see RQ8
    end
  end
endmodule

// ==== testbench/detector_model.sv ====
// Neutron detector model giving one count rate per division.
module detector_model (
  // Clock
  input wire logic clk_in,
  // Control from the bench
  input wire logic [3:0] up_in,
  input wire logic [bdb_pkg::RATE_W-1:0] base_in,
  input wire logic [bdb_pkg::RATE_W-1:0] hi_in,
  // Count rates
  output logic [bdb_pkg::RATE_W-1:0] rate_a_out,
  output logic [bdb_pkg::RATE_W-1:0] rate_b_out,
  output logic [bdb_pkg::RATE_W-1:0] rate_c_out,
  output logic [bdb_pkg::RATE_W-1:0] rate_d_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rates change only at a clock edge, so a step never lands mid-sample.
  always_ff @(posedge clk_in) begin
    rate_a_out <= up_in[0] ? hi_in : base_in;
    rate_b_out <= up_in[1] ? hi_in : base_in;
    rate_c_out <= up_in[2] ? hi_in : base_in;
    rate_d_out <= up_in[3] ? hi_in : base_in;
  end
endmodule

// ==== testbench/bdb_chk_sva.sv ====
// Assertion checker for the dilution block demand logic.
module bdb_chk (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Inputs
  input wire logic [7:0] UV_SENSE_IN,
  input wire logic [3:0] TRIP_ILK_IN,
  input wire logic MAN_BLOCK_IN,
  input wire logic MAN_RESET_IN,
  input wire logic BELOW_PERM_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  // Outputs
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic MAKEUP_ISO_CLOSE_OUT,
  input wire logic DEMIN_CLOSE_OUT,
  input wire logic ACID_ALIGN_OUT,
  input wire logic PUMP_TRIP_OUT,
  input wire logic FLUX_BLOCKED_OUT,
  input wire logic IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // Qualifying time is 100 ticks of 200 cycles, less slack for tick phase.
  localparam int UV_MIN = 19600;
  int uv_cnt;
  int ilk_age;
  int rst_age;
  logic loss_now;
  assign loss_now = (&UV_SENSE_IN[1:0] | &UV_SENSE_IN[5:4]) & (&UV_SENSE_IN[3:2] | &UV_SENSE_IN[7:6]);
  always_ff @(posedge CLK_IN) begin
    uv_cnt <= loss_now ? ((uv_cnt < 30000) ? uv_cnt + 1 : uv_cnt) : 0;
  end
  always_ff @(posedge CLK_IN) begin
    ilk_age <= ($countones(TRIP_ILK_IN) >= 2) ? 0 : ((ilk_age < 1000) ? ilk_age + 1 : ilk_age);
  end
  always_ff @(posedge CLK_IN) begin
    rst_age <= MAN_RESET_IN ? 0 : ((rst_age < 1000) ? rst_age + 1 : rst_age);
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  chk_iso_pump: assert property (MAKEUP_ISO_CLOSE_OUT == PUMP_TRIP_OUT)
    else $error("pump trip differs from makeup isolation");
  chk_demin_cause: assert property (DEMIN_CLOSE_OUT == (MAKEUP_ISO_CLOSE_OUT | ACID_ALIGN_OUT))
    else $error("water valve demand without matching cause");
  chk_reset_quiet: assert property ($past(RST_IN) |-> !(DEMIN_CLOSE_OUT | ACID_ALIGN_OUT | IRQ_OUT))
    else $error("output active right after reset");
  chk_latch_hold: assert property ($fell(DEMIN_CLOSE_OUT) |-> rst_age < 8)
    else $error("demand dropped without manual reset");
  chk_uv_delay: assert property ($rose(ACID_ALIGN_OUT) |-> (uv_cnt >= UV_MIN) || (ilk_age < 600))
    else $error("acid alignment before qualifying delay");
  chk_rd_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
    else $error("read data outside read slot");
  chk_mask_off: assert property (REG_WR_IN && REG_ADDR_IN == 4'h1 && REG_WDATA_IN[3:0] == 4'h0 |=> !IRQ_OUT)
    else $error("interrupt with all sources masked");
  chk_block_set: assert property ($rose(MAN_BLOCK_IN) && $stable(BELOW_PERM_IN) |-> ##[1:8] FLUX_BLOCKED_OUT)
    else $error("manual block not taken");
  cov_flux: cover property ($rose(MAKEUP_ISO_CLOSE_OUT));
  cov_power: cover property ($rose(ACID_ALIGN_OUT));
  cov_irq: cover property ($rose(IRQ_OUT));
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the dilution block demand logic.
`define CHK(n, e, a) begin \
  checked++; \
  if ((e) !== (a)) begin \
    fail_count++; \
    $display("BAD %s exp %h got %h", n, e, a); \
  end \
end
bind boron_dilution_block bdb_chk chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .UV_SENSE_IN(UV_SENSE_IN),
  .TRIP_ILK_IN(TRIP_ILK_IN), .MAN_BLOCK_IN(MAN_BLOCK_IN), .MAN_RESET_IN(MAN_RESET_IN),
  .BELOW_PERM_IN(BELOW_PERM_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .MAKEUP_ISO_CLOSE_OUT(MAKEUP_ISO_CLOSE_OUT),
  .DEMIN_CLOSE_OUT(DEMIN_CLOSE_OUT), .ACID_ALIGN_OUT(ACID_ALIGN_OUT), .PUMP_TRIP_OUT(PUMP_TRIP_OUT),
  .FLUX_BLOCKED_OUT(FLUX_BLOCKED_OUT), .IRQ_OUT(IRQ_OUT));
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = bdb_pkg::TICK_CYCLES;
  logic clk, rst, mb, mr, bp, wr, rd, iso, demin, acid, pump, blk, irq;
  logic [7:0] uv;
  logic [3:0] ilk, addr, up;
  logic [31:0] wdata, rdata, d;
  logic [15:0] ra, rb, rc, rdd, hi;
  int fail_count, checked;
  // Rows: interlock pattern, then expected {isolation, water, acid, pump}.
  logic [7:0] rows [5] = '{8'h10, 8'h36, 8'hA6, 8'hC6, 8'h40};
  boron_dilution_block dut_u (.CLK_IN(clk), .RST_IN(rst), .RATE_A_IN(ra), .RATE_B_IN(rb), .RATE_C_IN(rc),
    .RATE_D_IN(rdd), .UV_SENSE_IN(uv), .TRIP_ILK_IN(ilk), .MAN_BLOCK_IN(mb), .MAN_RESET_IN(mr),
    .BELOW_PERM_IN(bp), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .MAKEUP_ISO_CLOSE_OUT(iso), .DEMIN_CLOSE_OUT(demin), .ACID_ALIGN_OUT(acid),
    .PUMP_TRIP_OUT(pump), .FLUX_BLOCKED_OUT(blk), .IRQ_OUT(irq));
  detector_model src_u (.clk_in(clk), .up_in(up), .base_in(16'h0064), .hi_in(hi), .rate_a_out(ra),
    .rate_b_out(rb), .rate_c_out(rc), .rate_d_out(rdd));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic outs(input logic [3:0] e);
    `CHK("demands", e, {iso, demin, acid, pump})
  endtask
  task automatic clr;
    @(posedge clk);
    mr <= 1'b1;
    tk(1);
    mr <= 1'b0;
    tk(2);
  endtask
  // Step the chosen divisions, check after the average has settled, then
  // hold base long enough that the lagged average has forgotten the step by the next check.
  task automatic step(input logic [3:0] u, input logic [15:0] h, input logic [3:0] e);
    @(posedge clk);
    up <= u;
    hi <= h;
    tk(20);
    outs(e);
    up <= 4'h0;
    tk(35);
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The planned sequence needs about 96000 cycles.
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    {rst, mb, mr, bp, wr, rd} = 6'h20;
    rst = 1'b1;
    uv = 8'h00;
    ilk = 4'h0;
    addr = 4'h0;
    wdata = 32'h0;
    up = 4'h0;
    hi = 16'h0064;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    outs(4'h0);
    `CHK("blocked", 1'b0, blk)
    rreg(4'h2, d);
    `CHK("state", 32'h0, d)
    rreg(4'hF, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    foreach (rows[i]) begin
      ilk <= rows[i][7:4];
      tk(2);
      outs(rows[i][3:0]);
      ilk <= 4'h0;
      tk(2);
      outs(rows[i][3:0]);
      clr();
      outs(4'h0);
    end
    $display("test interlock rows done");
    rreg(4'h0, d);
    `CHK("power event", 1'b1, d[1])
    wreg(4'h1, 32'h2);
    #1 `CHK("irq on", 1'b1, irq)
    wreg(4'h0, 32'h2);
    #1 `CHK("irq off", 1'b0, irq)
    wreg(4'h1, 32'h0);
    wreg(4'hF, 32'hF);
    rreg(4'h1, d);
    `CHK("mask", 32'h0, d)
    wreg(4'h0, 32'hF);
    $display("test interrupt done");
    uv <= 8'h37;
    tk(102);
    outs(4'h0);
    uv <= 8'h3C;
    tk(95);
    outs(4'h0);
    tk(8);
    outs(4'h6);
    uv <= 8'h00;
    clr();
    outs(4'h0);
    $display("test undervoltage done");
    step(4'h1, 16'h012C, 4'h0);
    step(4'h6, 16'h00DC, 4'h0);
    step(4'h9, 16'h00DD, 4'hD);
    outs(4'hD);
    clr();
    outs(4'h0);
    $display("test flux doubling done");
    mb <= 1'b1;
    tk(1);
    `CHK("blocked", 1'b1, blk)
    step(4'h9, 16'h012C, 4'h0);
    bp <= 1'b1;
    tk(1);
    `CHK("reinstated", 1'b0, blk)
    mb <= 1'b0;
    tk(1);
    mb <= 1'b1;
    tk(1);
    `CHK("reblocked", 1'b1, blk)
    ilk <= 4'h3;
    tk(2);
    ilk <= 4'h0;
    clr();
    outs(4'h0);
    rreg(4'h0, d);
    `CHK("reinstate event", 1'b1, d[3])
    $display("test block done");
    // Reset in mid-run with a demand latched and block and permissive pins held.
    ilk <= 4'h3;
    tk(2);
    outs(4'h6);
    rst <= 1'b1;
    ilk <= 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tk(1);
    outs(4'h0);
    `CHK("blocked after reset", 1'b0, blk)
    rreg(4'h0, d);
    `CHK("status after reset", 32'h0, d)
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
